// ### rtl/remap_pkg.sv
// Purpose: Shared constants for the serial register address front end
// Assumes: 16-bit parameter addresses and data, 13-bit remap address range
// Notes:   Register indices are parameter numbers of the drive's own table
package remap_pkg;

  // Parameter indices of the remap settings
  localparam logic [15:0] IDX_REMAP_CONTROL      = 16'h0087;
  localparam logic [15:0] IDX_REMAP1_SOURCE      = 16'h0088;
  localparam logic [15:0] IDX_REMAP1_DESTINATION = 16'h0089;
  localparam logic [15:0] IDX_REMAP2_SOURCE      = 16'h008A;
  localparam logic [15:0] IDX_REMAP2_DESTINATION = 16'h008B;

  // Persistent base and RAM-only alias
  localparam logic [15:0] PARAM_BASE_ADDR = 16'h0300;
  localparam logic [15:0] RAM_ONLY_OFFSET = 16'h1000;
  localparam logic [15:0] ALIAS_MASK      = 16'h1000;

  // Field positions and limits
  localparam int          REMAP_ENABLE_BIT = 0;
  localparam int          REMAP_ADDR_W     = 13;
  localparam logic [15:0] REMAP_ADDR_MAX   = 16'h1FFF;

  // Reset values
  localparam logic [15:0] RST_REMAP_CONTROL = 16'h0000;
  localparam logic [15:0] RST_REMAP_ADDR    = 16'h0000;

  typedef enum logic [1:0] {
    SRC_RS485 = 2'b00,
    SRC_USB   = 2'b01
  } port_src_t;

endpackage : remap_pkg

// ### rtl/remap_entry.sv
// Purpose: One remap entry with source and destination settings
// Assumes: Writes are already decoded for this entry
// Notes:   Values above the range are refused and the setting holds
`timescale 1ns/10ps
module remap_entry (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Setting writes
  input  wire logic        src_wr,
  input  wire logic        dst_wr,
  input  wire logic [15:0] wr_data,
  // Lookup
  input  wire logic [15:0] addr_in,
  output logic             hit,
  output logic      [15:0] src_ff,
  output logic      [15:0] dst_ff
);

  logic [15:0] nxt_src;
  logic [15:0] nxt_dst;
  logic        in_range;

  always_comb begin
    in_range = (wr_data <= remap_pkg::REMAP_ADDR_MAX);
    nxt_src  = src_ff;
    nxt_dst  = dst_ff;
    if (src_wr && in_range) begin
      nxt_src = wr_data;
    end
    if (dst_wr && in_range) begin
      nxt_dst = wr_data;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      src_ff <= remap_pkg::RST_REMAP_ADDR;
      dst_ff <= remap_pkg::RST_REMAP_ADDR;
    end else begin
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
    end
  end

  assign hit = (addr_in == src_ff);

endmodule : remap_entry

// ### rtl/serial_register_address_remap.sv
// Purpose: Serial register access front end with NV alias and remapping
// Assumes: Link framing, CRC and UART sit upstream; one request per pulse
// Notes:   Answers one cycle after the request; setting writes need no remap
`timescale 1ns/10ps
module serial_register_address_remap (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Incoming access
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_from_usb,
  input  wire logic [15:0] req_addr,
  input  wire logic [15:0] req_wdata,
  // Outgoing parameter access
  output logic             acc_valid_ff,
  output logic             acc_write_ff,
  output logic      [15:0] acc_addr_ff,
  output logic      [15:0] acc_wdata_ff,
  output logic             ram_write_ff,
  output logic             nv_commit_ff,
  output logic             remapped_ff,
  // Setting readback
  output logic             set_rvalid_ff,
  output logic      [15:0] set_rdata_ff,
  output logic             remap_enable_ff
);

  logic [15:0] src1;
  logic [15:0] dst1;
  logic [15:0] src2;
  logic [15:0] dst2;
  logic        hit1;
  logic        hit2;
  logic        wr_setting;
  logic        ctl_wr;
  logic [15:0] phys_addr;
  logic        do_remap;
  logic [15:0] tgt;
  logic        nxt_acc_valid;
  logic        nxt_acc_write;
  logic [15:0] nxt_acc_addr;
  logic [15:0] nxt_acc_wdata;
  logic        nxt_ram_write;
  logic        nxt_nv_commit;
  logic        nxt_remapped;
  logic        nxt_set_rvalid;
  logic [15:0] nxt_set_rdata;
  logic        nxt_remap_enable;

  // Settings hit on their physical index, alias bit stripped
  assign phys_addr  = req_addr & ~remap_pkg::ALIAS_MASK;
  assign wr_setting = req_valid && req_write;
  assign ctl_wr     = wr_setting && (phys_addr == remap_pkg::IDX_REMAP_CONTROL);

  remap_entry u_entry1 (
    .clock   (clock),
    .rst_b   (rst_b),
    .src_wr  (wr_setting && (phys_addr == remap_pkg::IDX_REMAP1_SOURCE)),
    .dst_wr  (wr_setting && (phys_addr == remap_pkg::IDX_REMAP1_DESTINATION)),
    .wr_data (req_wdata),
    .addr_in (req_addr),
    .hit     (hit1),
    .src_ff  (src1),
    .dst_ff  (dst1)
  );

  remap_entry u_entry2 (
    .clock   (clock),
    .rst_b   (rst_b),
    .src_wr  (wr_setting && (phys_addr == remap_pkg::IDX_REMAP2_SOURCE)),
    .dst_wr  (wr_setting && (phys_addr == remap_pkg::IDX_REMAP2_DESTINATION)),
    .wr_data (req_wdata),
    .addr_in (req_addr),
    .hit     (hit2),
    .src_ff  (src2),
    .dst_ff  (dst2)
  );

  always_comb begin
    nxt_remap_enable = remap_enable_ff;
    if (ctl_wr && (req_wdata[15:1] == 15'h0000)) begin
      nxt_remap_enable = req_wdata[remap_pkg::REMAP_ENABLE_BIT];
    end
    do_remap = remap_enable_ff && !req_from_usb;
    tgt      = req_addr;
    if (do_remap && hit1) begin
      tgt = dst1;
    end else if (do_remap && hit2) begin
      tgt = dst2;
    end
    nxt_acc_valid  = req_valid;
    nxt_acc_write  = req_valid && req_write;
    nxt_acc_addr   = req_valid ? tgt : acc_addr_ff;
    nxt_acc_wdata  = req_valid ? req_wdata : acc_wdata_ff;
    nxt_remapped   = req_valid && (tgt != req_addr);
    nxt_ram_write  = req_valid && req_write;
    nxt_nv_commit  = req_valid && req_write && ((tgt & remap_pkg::ALIAS_MASK) == 16'h0000);
    nxt_set_rvalid = req_valid && !req_write;
    case (phys_addr)
      remap_pkg::IDX_REMAP_CONTROL:      nxt_set_rdata = {15'h0000, remap_enable_ff};
      remap_pkg::IDX_REMAP1_SOURCE:      nxt_set_rdata = src1;
      remap_pkg::IDX_REMAP1_DESTINATION: nxt_set_rdata = dst1;
      remap_pkg::IDX_REMAP2_SOURCE:      nxt_set_rdata = src2;
      remap_pkg::IDX_REMAP2_DESTINATION: nxt_set_rdata = dst2;
      default:                           nxt_set_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      remap_enable_ff <= 1'b0;
      acc_valid_ff    <= 1'b0;
      acc_write_ff    <= 1'b0;
      acc_addr_ff     <= 16'h0000;
      acc_wdata_ff    <= 16'h0000;
      ram_write_ff    <= 1'b0;
      nv_commit_ff    <= 1'b0;
      remapped_ff     <= 1'b0;
      set_rvalid_ff   <= 1'b0;
      set_rdata_ff    <= 16'h0000;
    end else begin
      remap_enable_ff <= nxt_remap_enable;
      acc_valid_ff    <= nxt_acc_valid;
      acc_write_ff    <= nxt_acc_write;
      acc_addr_ff     <= nxt_acc_addr;
      acc_wdata_ff    <= nxt_acc_wdata;
      ram_write_ff    <= nxt_ram_write;
      nv_commit_ff    <= nxt_nv_commit;
      remapped_ff     <= nxt_remapped;
      set_rvalid_ff   <= nxt_set_rvalid;
      set_rdata_ff    <= nxt_set_rdata;
    end
  end

  // Persistent write commits
  property p_base_commit;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && req_write && (req_from_usb || !remap_enable_ff)
       && req_addr == remap_pkg::PARAM_BASE_ADDR) |=> (ram_write_ff && nv_commit_ff);
  endproperty
  a_base_commit: assert property (p_base_commit) else $error("base write not committed");

  // RAM-only alias commits only when remapped to a persistent address
  property p_alias_ram_only;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && req_write && (req_from_usb || !remap_enable_ff)
       && req_addr == (remap_pkg::PARAM_BASE_ADDR + remap_pkg::RAM_ONLY_OFFSET))
      |=> (ram_write_ff && !nv_commit_ff);
  endproperty
  a_alias_ram_only: assert property (p_alias_ram_only) else $error("alias write committed");

  // Entry one redirect
  property p_remap1;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && remap_enable_ff && !req_from_usb && req_addr == src1)
      |=> (acc_valid_ff && acc_addr_ff == $past(dst1));
  endproperty
  a_remap1: assert property (p_remap1) else $error("entry one not applied");

  // Disabled means pass-through
  property p_disabled_pass;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && !remap_enable_ff) |=> (acc_addr_ff == $past(req_addr));
  endproperty
  a_disabled_pass: assert property (p_disabled_pass) else $error("remap while disabled");

  // Settings stay in range
  property p_range;
    @(posedge clock) disable iff (!rst_b)
      (src1 <= remap_pkg::REMAP_ADDR_MAX) && (dst1 <= remap_pkg::REMAP_ADDR_MAX)
      && (src2 <= remap_pkg::REMAP_ADDR_MAX) && (dst2 <= remap_pkg::REMAP_ADDR_MAX);
  endproperty
  a_range: assert property (p_range) else $error("remap setting out of range");

  // Entry two applies alone
  property p_remap2;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && remap_enable_ff && !req_from_usb && req_addr == src2 && req_addr != src1)
      |=> (acc_addr_ff == $past(dst2));
  endproperty
  a_remap2: assert property (p_remap2) else $error("entry two not applied");

  // USB unaffected
  property p_usb_pass;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && req_from_usb) |=> (acc_addr_ff == $past(req_addr) && !remapped_ff);
  endproperty
  a_usb_pass: assert property (p_usb_pass) else $error("usb access remapped");

  // No match passes unchanged
  property p_nomatch;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && req_addr != src1 && req_addr != src2) |=> (acc_addr_ff == $past(req_addr));
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("unmatched access moved");

  // Entry one wins when both match
  property p_priority;
    @(posedge clock) disable iff (!rst_b)
      (req_valid && remap_enable_ff && !req_from_usb && req_addr == src1 && req_addr == src2)
      |=> (acc_addr_ff == $past(dst1));
  endproperty
  a_priority: assert property (p_priority) else $error("entry one did not win");

  // Enable values above one are refused
  property p_enable_refuse;
    @(posedge clock) disable iff (!rst_b)
      (ctl_wr && req_wdata > 16'h0001) |=> $stable(remap_enable_ff);
  endproperty
  a_enable_refuse: assert property (p_enable_refuse) else $error("bad enable taken");

  // No commit to a RAM-only final address
  property p_alias_no_commit;
    @(posedge clock) disable iff (!rst_b)
      nv_commit_ff |-> (acc_write_ff && (acc_addr_ff & remap_pkg::ALIAS_MASK) == 16'h0000);
  endproperty
  a_alias_no_commit: assert property (p_alias_no_commit) else $error("alias commit");

endmodule : serial_register_address_remap

// ### bench/link_master.sv
// Purpose: Serial link master model issuing one parameter access at a time
// Assumes: Requests launched just after a rising edge, taken at the next one
// Notes:   Released fields show the inverse of their last value
`timescale 1ns/10ps
module link_master (
  // Clock
  input  wire logic        clock,
  // Access request
  output logic             req_valid,
  output logic             req_write,
  output logic             req_from_usb,
  output logic      [15:0] req_addr,
  output logic      [15:0] req_wdata
);
  initial begin
    req_valid    = 1'b0;
    req_write    = 1'b0;
    req_from_usb = 1'b0;
    req_addr     = 16'h0000;
    req_wdata    = 16'h0000;
  end

  // Persistent writes kept to a handful per run
  task automatic access(input logic wr, input logic usb, input logic [15:0] a,
                        input logic [15:0] d);
    @(posedge clock);
    req_valid    <= 1'b1;
    req_write    <= wr;
    req_from_usb <= usb;
    req_addr     <= a;
    req_wdata    <= d;
    @(posedge clock);
    req_valid    <= 1'b0;
    req_write    <= ~wr;
    req_from_usb <= ~usb;
    req_addr     <= ~a;
    req_wdata    <= ~d;
  endtask : access
endmodule : link_master

// ### bench/tb_top.sv
// Purpose: Self-checking bench for the serial register address front end
// Assumes: Outputs valid one cycle after the request is launched
// Notes:   Reset readback first, then table rows, then refusal and mid-run reset cases by hand
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic wr; logic usb; logic [15:0] a; logic [15:0] d; logic [15:0] ea; logic [2:0] ef;
  } row_t;
  logic clock, rst_b, req_valid, req_write, req_from_usb;
  logic [15:0] req_addr, req_wdata, acc_addr_ff, acc_wdata_ff, set_rdata_ff;
  logic acc_valid_ff, acc_write_ff, ram_write_ff, nv_commit_ff, remapped_ff;
  logic set_rvalid_ff, remap_enable_ff;
  int   errors = 0;
  int   compares = 0;
  // Expected flags are {ram, nv, remapped}
  row_t rows [12] = '{
    '{1, 0, 16'h0300, 16'h0001, 16'h0300, 3'b110},
    '{1, 0, 16'h1300, 16'h0002, 16'h1300, 3'b100},
    '{1, 0, 16'h0087, 16'h0001, 16'h0087, 3'b110},
    '{1, 0, 16'h0088, 16'h0A00, 16'h0088, 3'b110},
    '{1, 0, 16'h0089, 16'h0304, 16'h0089, 3'b110},
    '{1, 0, 16'h008A, 16'h0B00, 16'h008A, 3'b110},
    '{1, 0, 16'h008B, 16'h1305, 16'h008B, 3'b110},
    '{1, 0, 16'h0A00, 16'h0005, 16'h0304, 3'b111},
    '{0, 0, 16'h0B00, 16'h0000, 16'h1305, 3'b001},
    '{1, 1, 16'h0A00, 16'h0006, 16'h0A00, 3'b110},
    '{1, 0, 16'h0A01, 16'h0007, 16'h0A01, 3'b110},
    '{1, 0, 16'h0B00, 16'h0008, 16'h1305, 3'b101}
  };

  serial_register_address_remap serial_register_address_remap_inst (
    .clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
    .req_from_usb(req_from_usb), .req_addr(req_addr), .req_wdata(req_wdata),
    .acc_valid_ff(acc_valid_ff), .acc_write_ff(acc_write_ff), .acc_addr_ff(acc_addr_ff),
    .acc_wdata_ff(acc_wdata_ff), .ram_write_ff(ram_write_ff), .nv_commit_ff(nv_commit_ff),
    .remapped_ff(remapped_ff), .set_rvalid_ff(set_rvalid_ff), .set_rdata_ff(set_rdata_ff),
    .remap_enable_ff(remap_enable_ff));

  link_master link_master_inst (
    .clock(clock), .req_valid(req_valid), .req_write(req_write),
    .req_from_usb(req_from_usb), .req_addr(req_addr), .req_wdata(req_wdata));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic run(input row_t r);
    link_master_inst.access(r.wr, r.usb, r.a, r.d);
    #1;
    chk_bit(acc_valid_ff, 1'b1);
    chk_bit(acc_write_ff, r.wr);
    chk_word(acc_addr_ff, r.ea);
    chk_word(acc_wdata_ff, r.d);
    chk_bit(ram_write_ff, r.ef[2]);
    chk_bit(nv_commit_ff, r.ef[1]);
    chk_bit(remapped_ff, r.ef[0]);
    chk_bit(set_rvalid_ff, ~r.wr);
  endtask : run

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    link_master_inst.access(1'b0, 1'b0, a, 16'h0000);
    #1;
    chk_bit(set_rvalid_ff, 1'b1);
    chk_word(set_rdata_ff, exp);
  endtask : rd

  task automatic finish_test;
    $display("Counts: compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  initial begin
    #80000;
    errors++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk_bit(remap_enable_ff, 1'b0);
    for (int i = 8; i < 12; i++) begin
      rd(16'h0080 + 16'(i), 16'h0000);
    end
    $display("Test reset done");
    foreach (rows[i]) begin
      run(rows[i]);
    end
    $display("Test table done");
    rd(16'h0087, 16'h0001);
    rd(16'h0300, 16'h0000);
    rd(16'h0088, 16'h0A00);
    run('{1, 0, 16'h0088, 16'h2000, 16'h0088, 3'b110});
    rd(16'h0088, 16'h0A00);
    run('{1, 0, 16'h0087, 16'h0002, 16'h0087, 3'b110});
    chk_bit(remap_enable_ff, 1'b1);
    run('{1, 0, 16'h008A, 16'h0A00, 16'h008A, 3'b110});
    run('{1, 0, 16'h0A00, 16'h0009, 16'h0304, 3'b111});
    run('{1, 0, 16'h0087, 16'h0000, 16'h0087, 3'b110});
    run('{0, 0, 16'h0A00, 16'h0000, 16'h0A00, 3'b000});
    chk_bit(remap_enable_ff, 1'b0);
    $display("Test refusal done");
    run('{1, 0, 16'h0087, 16'h0001, 16'h0087, 3'b110});
    chk_bit(remap_enable_ff, 1'b1);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk_bit(remap_enable_ff, 1'b0);
    rd(16'h0088, 16'h0000);
    rd(16'h008B, 16'h0000);
    $display("Test mid reset done");
    finish_test();
  end
endmodule : tb_top
